// *** hw/lstm_fifo.sv ***
`timescale 1ns/1ns
module lstm_fifo
#(
    parameter int WIDTH = 26,
    parameter int DEPTH = 32
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    lstm_fifo_if.store f
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    // Honest flags: full stalls the sequencer, empty holds the drain
    assign f.in_ready = (count_ff != FULL_CNT);
    assign f.out_valid = (count_ff != '0);
    assign f.out_data = mem_ff[rd_ptr_ff];
    assign push = f.in_valid && f.in_ready;
    assign pop = f.out_valid && f.out_ready;

    // Storage, written at the tail
    always_ff @(posedge clk_sys)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff] <= f.in_data;
        end
    end

    // Pointers wrap explicitly so any depth works
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= (wr_ptr_ff == LAST_PTR) ? '0 : wr_ptr_ff + AW'(1);
            end
            if (pop)
            begin
                rd_ptr_ff <= (rd_ptr_ff == LAST_PTR) ? '0 : rd_ptr_ff + AW'(1);
            end
        end
    end

    // Fill level
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            count_ff <= '0;
        end
        else if (push && !pop)
        begin
            count_ff <= count_ff + (AW+1)'(1);
        end
        else if (pop && !push)
        begin
            count_ff <= count_ff - (AW+1)'(1);
        end
    end
endmodule : lstm_fifo

// *** hw/lstm_fifo_if.sv ***
`timescale 1ns/1ns
// Carrier between the sequencer and the link write buffer
interface lstm_fifo_if #(parameter int WIDTH = 26);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport user (output in_valid, output in_data, input in_ready, input out_valid, input out_data, output out_ready);
    modport store (input in_valid, input in_data, output in_ready, output out_valid, output out_data, input out_ready);
endinterface : lstm_fifo_if

// *** hw/lstm_pkg.sv ***
// Function
// - On the large-ring module type the 1024-word link space is cut into 64-word blocks, each set per channel.
// - A block whose setting is blank is never transferred, so its link registers stay untouched.
// - In an attached block the copy direction is chosen per word from the send or receive flag the module reports.
// - In a bridge block, the receiving channel's word goes both to the link register and to the sending channel.
// - In a bridge block where both channels send, the link register is copied out to both channels.
// - In a bridge block where both channels receive, only the channel holding the bridge setting loads the link.
// - A block set on both channels keeps the first channel's setting and the second one's is ignored.
// - Each small-bus module exposes a scan memory of exactly 32 words.
// - Up to eight small-bus modules are served, numbered one to eight from the one nearest the CPU.
// - Attached small-bus channels get consecutive 32-word link slices, channel one at the lowest address.
// - On the small bus the direction of each word comes from that module's own network configuration.
package lstm_pkg;
    localparam int LSTM_LR_WORDS = 1024;
    localparam int LSTM_ADDR_W = 10;
    localparam int LSTM_DATA_W = 16;
    localparam int LSTM_BLOCK_WORDS = 64;
    localparam int LSTM_BLOCKS = 16;
    localparam int LSTM_BLK_LSB = 6;
    localparam int LSTM_RING_PORTS = 2;
    localparam int LSTM_BUS_WORDS = 32;
    localparam int LSTM_BUS_PORTS = 8;
    localparam int LSTM_FIFO_DEPTH = 32;
    // Assignment table layout: two bits per block, 32 bits per ring channel
    localparam int LSTM_ASG_W = 2;
    localparam int LSTM_ASG_PORT_STRIDE = 32;
    localparam int LSTM_ASG_TBL_W = 64;
    // Reset values, walk limits and the second ring channel index
    localparam logic [9:0] LSTM_WORD_RST = 10'h000;
    localparam logic [2:0] LSTM_PORT_RST = 3'h0;
    localparam logic [15:0] LSTM_DATA_RST = 16'h0000;
    localparam logic [9:0] LSTM_LAST_RING_WORD = 10'h3ff;
    localparam logic [4:0] LSTM_LAST_BUS_WORD = 5'h1f;
    localparam logic [2:0] LSTM_LAST_BUS_PORT = 3'h7;
    localparam logic [2:0] LSTM_RING_PORT_B = 3'h1;

    typedef enum logic [1:0] {
        LSTM_ASG_BLANK = 2'b00,
        LSTM_ASG_LINK = 2'b01,
        LSTM_ASG_GLOBAL = 2'b10
    } lstm_asg_t;

    typedef enum logic [3:0] {
        LSTM_ST_IDLE = 4'b0000,
        LSTM_ST_PICK = 4'b0001,
        LSTM_ST_RDA = 4'b0010,
        LSTM_ST_RDB = 4'b0011,
        LSTM_ST_DECIDE = 4'b0100,
        LSTM_ST_LRD = 4'b0101,
        LSTM_ST_WRA = 4'b0110,
        LSTM_ST_WRB = 4'b0111,
        LSTM_ST_PUSH = 4'b1000,
        LSTM_ST_ADV = 4'b1001,
        LSTM_ST_DRAIN = 4'b1010
    } lstm_state_t;
endpackage : lstm_pkg

// *** hw/lstm_top.sv ***
`timescale 1ns/1ns
module lstm_top
    import lstm_pkg::*;
#(
    parameter int DATA_W = LSTM_DATA_W,
    parameter int FIFO_DEPTH = LSTM_FIFO_DEPTH
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic scan_start,
    input wire logic cfg_bus_mode,
    input wire logic [LSTM_ASG_TBL_W-1:0] cfg_ring_asg,
    input wire logic [LSTM_BUS_PORTS-1:0] cfg_bus_attached,
    output logic busy_ff,
    output logic done_ff,
    output logic sc_req_ff,
    output logic sc_we_ff,
    output logic [2:0] sc_network_port_index_ff,
    output logic [LSTM_ADDR_W-1:0] sc_addr_ff,
    output logic [DATA_W-1:0] sc_wdata_ff,
    input wire logic sc_ack,
    input wire logic [DATA_W-1:0] sc_rdata,
    input wire logic sc_send,
    output logic lr_rd_req_ff,
    output logic [LSTM_ADDR_W-1:0] lr_rd_addr_ff,
    input wire logic lr_rd_ack,
    input wire logic [DATA_W-1:0] lr_rd_data,
    output logic lw_valid_ff,
    output logic [LSTM_ADDR_W-1:0] lw_addr_ff,
    output logic [DATA_W-1:0] lw_data_ff,
    input wire logic lw_ready
);
    localparam int FW = LSTM_ADDR_W + DATA_W;

    lstm_state_t state_ff;
    logic [LSTM_ADDR_W-1:0] word_ff;
    logic [2:0] chan_ff;
    logic glob_ff;
    logic own_b_ff;
    logic [2:0] port_a_ff;
    logic send_a_ff;
    logic send_b_ff;
    logic [DATA_W-1:0] data_a_ff;
    logic [DATA_W-1:0] data_b_ff;
    logic [DATA_W-1:0] xfer_ff;
    logic need_lrd_ff;
    logic wr_a_ff;
    logic wr_b_ff;
    logic push_ff;
    lstm_asg_t set_1;
    lstm_asg_t set_2;
    lstm_asg_t eff;
    logic eff_own_b;
    logic [2:0] eff_port;
    logic [LSTM_ADDR_W-1:0] scan_addr;
    logic [LSTM_ADDR_W-1:0] link_addr;
    logic last_word;
    logic [DATA_W-1:0] lrd_word;

    lstm_fifo_if #(.WIDTH(FW)) wq ();

    // Setting of one ring channel for one block
    function automatic lstm_asg_t asg_of(input logic [LSTM_ASG_TBL_W-1:0] tbl, input int p, input logic [3:0] blk);
        int idx;
        idx = LSTM_ASG_PORT_STRIDE * p + LSTM_ASG_W * int'(blk);
        return lstm_asg_t'(tbl[idx +: LSTM_ASG_W]);
    endfunction : asg_of

    // Slice number of a small-bus channel: attached channels below it
    function automatic logic [2:0] slice_of(input logic [LSTM_BUS_PORTS-1:0] att, input logic [2:0] ch);
        logic [2:0] cnt;
        cnt = 3'h0;
        for (int i = 0; i < LSTM_BUS_PORTS; i++)
        begin
            if (i < int'(ch) && att[i])
            begin
                cnt = cnt + 3'h1;
            end
        end
        return cnt;
    endfunction : slice_of

    // Block decode for the ring; first channel's setting shadows the second
    always_comb
    begin
        set_1 = asg_of(cfg_ring_asg, 0, word_ff[LSTM_ADDR_W-1:LSTM_BLK_LSB]);
        set_2 = asg_of(cfg_ring_asg, 1, word_ff[LSTM_ADDR_W-1:LSTM_BLK_LSB]);
        if (cfg_bus_mode)
        begin
            eff = cfg_bus_attached[chan_ff] ? LSTM_ASG_LINK : LSTM_ASG_BLANK;
            eff_own_b = 1'b0;
            eff_port = chan_ff;
        end
        else if (set_1 != LSTM_ASG_BLANK)
        begin
            eff = set_1;
            eff_own_b = 1'b0;
            eff_port = LSTM_PORT_RST;
        end
        else
        begin
            eff = set_2;
            eff_own_b = 1'b1;
            eff_port = LSTM_RING_PORT_B;
        end
    end

    // Address mapping: scan word equals link index, bus slices are stacked
    assign scan_addr = cfg_bus_mode ? {5'h00, word_ff[4:0]} : word_ff;
    assign link_addr = cfg_bus_mode ? {2'b00, slice_of(cfg_bus_attached, chan_ff), word_ff[4:0]} : word_ff;
    assign last_word = cfg_bus_mode ? (chan_ff == LSTM_LAST_BUS_PORT && (word_ff[4:0] == LSTM_LAST_BUS_WORD
                                       || eff == LSTM_ASG_BLANK)) : (word_ff == LSTM_LAST_RING_WORD);
    assign lrd_word = need_lrd_ff ? lr_rd_data : xfer_ff;

    // Link writes queue in the buffer; a full buffer holds the sequencer in PUSH
    assign wq.in_valid = (state_ff == LSTM_ST_PUSH) && push_ff;
    assign wq.in_data = {link_addr, xfer_ff};
    assign wq.out_ready = !lw_valid_ff || lw_ready;

    lstm_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_wq (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .f(wq.store)
    );

    // Word and channel walk; a blank small-bus channel is skipped whole
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst || state_ff == LSTM_ST_IDLE)
        begin
            word_ff <= LSTM_WORD_RST;
            chan_ff <= LSTM_PORT_RST;
        end
        else if (state_ff == LSTM_ST_ADV && !last_word)
        begin
            if (cfg_bus_mode && (word_ff[4:0] == LSTM_LAST_BUS_WORD || eff == LSTM_ASG_BLANK))
            begin
                word_ff <= LSTM_WORD_RST;
                chan_ff <= chan_ff + 3'h1;
            end
            else
            begin
                word_ff <= word_ff + 10'h001;
            end
        end
    end

    // Sequencer with the scan and link read ports
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            state_ff <= LSTM_ST_IDLE;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            sc_req_ff <= 1'b0;
            sc_we_ff <= 1'b0;
            sc_network_port_index_ff <= LSTM_PORT_RST;
            sc_addr_ff <= LSTM_WORD_RST;
            sc_wdata_ff <= LSTM_DATA_RST;
            lr_rd_req_ff <= 1'b0;
            lr_rd_addr_ff <= LSTM_WORD_RST;
            glob_ff <= 1'b0;
            own_b_ff <= 1'b0;
            port_a_ff <= LSTM_PORT_RST;
            send_a_ff <= 1'b0;
            send_b_ff <= 1'b0;
            data_a_ff <= LSTM_DATA_RST;
            data_b_ff <= LSTM_DATA_RST;
            xfer_ff <= LSTM_DATA_RST;
            need_lrd_ff <= 1'b0;
            wr_a_ff <= 1'b0;
            wr_b_ff <= 1'b0;
            push_ff <= 1'b0;
        end
        else
        begin
            done_ff <= 1'b0;
            case (state_ff)
                LSTM_ST_IDLE:
                begin
                    if (scan_start)
                    begin
                        busy_ff <= 1'b1;
                        state_ff <= LSTM_ST_PICK;
                    end
                end
                LSTM_ST_PICK:
                begin
                    if (eff == LSTM_ASG_BLANK)
                    begin
                        state_ff <= LSTM_ST_ADV;
                    end
                    else
                    begin
                        // A bridge block always reads channel one first, then two
                        glob_ff <= (eff == LSTM_ASG_GLOBAL);
                        own_b_ff <= eff_own_b;
                        port_a_ff <= (eff == LSTM_ASG_GLOBAL) ? LSTM_PORT_RST : eff_port;
                        sc_network_port_index_ff <= (eff == LSTM_ASG_GLOBAL) ? LSTM_PORT_RST : eff_port;
                        sc_addr_ff <= scan_addr;
                        sc_we_ff <= 1'b0;
                        sc_req_ff <= 1'b1;
                        state_ff <= LSTM_ST_RDA;
                    end
                end
                LSTM_ST_RDA:
                begin
                    if (sc_ack)
                    begin
                        data_a_ff <= sc_rdata;
                        send_a_ff <= sc_send;
                        // A bridge keeps the request up and turns to channel two
                        sc_network_port_index_ff <= LSTM_RING_PORT_B;
                        sc_req_ff <= glob_ff;
                        state_ff <= glob_ff ? LSTM_ST_RDB : LSTM_ST_DECIDE;
                    end
                end
                LSTM_ST_RDB:
                begin
                    if (sc_ack)
                    begin
                        sc_req_ff <= 1'b0;
                        data_b_ff <= sc_rdata;
                        send_b_ff <= sc_send;
                        state_ff <= LSTM_ST_DECIDE;
                    end
                end
                LSTM_ST_DECIDE:
                begin
                    state_ff <= LSTM_ST_LRD;
                    lr_rd_addr_ff <= link_addr;
                    if (!glob_ff)
                    begin
                        // Attached block: send copies link out, receive copies link in
                        need_lrd_ff <= send_a_ff;
                        lr_rd_req_ff <= send_a_ff;
                        wr_a_ff <= send_a_ff;
                        wr_b_ff <= 1'b0;
                        push_ff <= !send_a_ff;
                        xfer_ff <= data_a_ff;
                    end
                    else
                    begin
                        need_lrd_ff <= send_a_ff && send_b_ff;
                        lr_rd_req_ff <= send_a_ff && send_b_ff;
                        wr_a_ff <= send_a_ff;
                        wr_b_ff <= send_b_ff;
                        push_ff <= !(send_a_ff && send_b_ff);
                        xfer_ff <= (send_a_ff || (!send_b_ff && own_b_ff)) ? data_b_ff : data_a_ff;
                    end
                end
                LSTM_ST_LRD:
                begin
                    if (!need_lrd_ff || lr_rd_ack)
                    begin
                        lr_rd_req_ff <= 1'b0;
                        xfer_ff <= lrd_word;
                        sc_wdata_ff <= lrd_word;
                        sc_network_port_index_ff <= port_a_ff;
                        sc_we_ff <= 1'b1;
                        sc_req_ff <= wr_a_ff;
                        state_ff <= LSTM_ST_WRA;
                    end
                end
                LSTM_ST_WRA:
                begin
                    if (!wr_a_ff || sc_ack)
                    begin
                        sc_network_port_index_ff <= LSTM_RING_PORT_B;
                        sc_req_ff <= wr_b_ff;
                        state_ff <= LSTM_ST_WRB;
                    end
                end
                LSTM_ST_WRB:
                begin
                    if (!wr_b_ff || sc_ack)
                    begin
                        sc_req_ff <= 1'b0;
                        sc_we_ff <= 1'b0;
                        state_ff <= LSTM_ST_PUSH;
                    end
                end
                LSTM_ST_PUSH:
                begin
                    if (!push_ff || wq.in_ready)
                    begin
                        state_ff <= LSTM_ST_ADV;
                    end
                end
                LSTM_ST_ADV:
                begin
                    state_ff <= last_word ? LSTM_ST_DRAIN : LSTM_ST_PICK;
                end
                LSTM_ST_DRAIN:
                begin
                    // Done only once every link write has left the buffer
                    if (!wq.out_valid && !lw_valid_ff)
                    begin
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                        state_ff <= LSTM_ST_IDLE;
                    end
                end
                default:
                begin
                    state_ff <= LSTM_ST_IDLE;
                end
            endcase
        end
    end

    // Link write port, reloaded from the buffer head
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            lw_valid_ff <= 1'b0;
            lw_addr_ff <= LSTM_WORD_RST;
            lw_data_ff <= LSTM_DATA_RST;
        end
        else if (wq.out_valid && wq.out_ready)
        begin
            lw_valid_ff <= 1'b1;
            lw_addr_ff <= wq.out_data[FW-1:DATA_W];
            lw_data_ff <= wq.out_data[DATA_W-1:0];
        end
        else if (lw_ready)
        begin
            lw_valid_ff <= 1'b0;
        end
    end
endmodule : lstm_top

// *** sim/lstm_scan_model.sv ***
`timescale 1ns/1ns
module lstm_scan_model
    import lstm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic sc_req_ff,
    input wire logic sc_we_ff,
    input wire logic [2:0] sc_network_port_index_ff,
    input wire logic [LSTM_ADDR_W-1:0] sc_addr_ff,
    input wire logic [LSTM_DATA_W-1:0] sc_wdata_ff,
    output logic sc_ack,
    output logic [LSTM_DATA_W-1:0] sc_rdata,
    output logic sc_send
);
    // Scan memories of all channels, word k of channel p at p*1024+k
    logic [LSTM_DATA_W-1:0] mem [8192];
    logic [1:0] wait_ff;
    logic slow_ff;
    initial
    begin
        for (int i = 0; i < 8192; i++)
            mem[i] = 16'(i * 37 + 5);
    end
    // Answers alternate fast and slow; released lines flip so stale data never looks valid
    always @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            sc_ack <= 1'h0;
            sc_rdata <= 16'h0000;
            sc_send <= 1'h0;
            wait_ff <= 2'h0;
            slow_ff <= 1'h0;
        end
        else if (sc_ack)
        begin
            sc_ack <= 1'h0;
            wait_ff <= 2'h0;
            sc_rdata <= ~sc_rdata;
            sc_send <= ~sc_send;
            if (sc_we_ff)
                mem[{sc_network_port_index_ff, sc_addr_ff}] <= sc_wdata_ff;
        end
        else if (sc_req_ff)
        begin
            if (wait_ff >= {slow_ff, 1'h0})
            begin
                sc_ack <= 1'h1;
                sc_rdata <= mem[{sc_network_port_index_ff, sc_addr_ff}];
                sc_send <= sc_addr_ff[sc_network_port_index_ff + 1];
                slow_ff <= ~slow_ff;
            end
            else
                wait_ff <= wait_ff + 2'h1;
        end
    end
endmodule : lstm_scan_model

// *** sim/lstm_top_assertions.sv ***
`timescale 1ns/1ns
module lstm_top_assertions
    import lstm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cfg_bus_mode,
    input wire logic [LSTM_ASG_TBL_W-1:0] cfg_ring_asg,
    input wire logic [LSTM_BUS_PORTS-1:0] cfg_bus_attached,
    input wire logic sc_req_ff,
    input wire logic sc_we_ff,
    input wire logic [2:0] sc_network_port_index_ff,
    input wire logic [LSTM_ADDR_W-1:0] sc_addr_ff,
    input wire logic sc_ack,
    input wire logic lr_rd_req_ff,
    input wire logic [LSTM_ADDR_W-1:0] lr_rd_addr_ff,
    input wire logic lw_valid_ff,
    input wire logic [LSTM_ADDR_W-1:0] lw_addr_ff
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Settings of the block holding the current scan word and link write
    logic [1:0] sa, sb, la, lb;
    assign sa = cfg_ring_asg[2 * sc_addr_ff[9:6] +: 2];
    assign sb = cfg_ring_asg[32 + 2 * sc_addr_ff[9:6] +: 2];
    assign la = cfg_ring_asg[2 * lw_addr_ff[9:6] +: 2];
    assign lb = cfg_ring_asg[32 + 2 * lw_addr_ff[9:6] +: 2];

    property p_req_hold;
        sc_req_ff && !sc_ack |=> sc_req_ff && $stable({sc_we_ff, sc_network_port_index_ff, sc_addr_ff});
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("scan request changed before ack");
    property p_ring_blank;
        !cfg_bus_mode && sc_req_ff |-> (sa | sb) != 2'h0;
    endproperty
    a_ring_blank: assert property (p_ring_blank) else $error("scan access in blank block");
    property p_ring_dup;
        !cfg_bus_mode && sc_req_ff && sa != 2'h0 && sa != LSTM_ASG_GLOBAL |-> sc_network_port_index_ff == 3'h0;
    endproperty
    a_ring_dup: assert property (p_ring_dup) else $error("second channel setting not ignored");
    property p_ring_port;
        !cfg_bus_mode && sc_req_ff |-> sc_network_port_index_ff <= 3'h1;
    endproperty
    a_ring_port: assert property (p_ring_port) else $error("ring channel out of range");
    property p_bus_slot;
        cfg_bus_mode && sc_req_ff |-> sc_addr_ff < 32 && cfg_bus_attached[sc_network_port_index_ff];
    endproperty
    a_bus_slot: assert property (p_bus_slot) else $error("bus access outside attached memory");
    property p_lw_blank;
        !cfg_bus_mode && lw_valid_ff |-> (la | lb) != 2'h0;
    endproperty
    a_lw_blank: assert property (p_lw_blank) else $error("link write into blank block");
    property p_bus_slice;
        cfg_bus_mode && lw_valid_ff |-> lw_addr_ff < 32 * $countones(cfg_bus_attached);
    endproperty
    a_bus_slice: assert property (p_bus_slice) else $error("link write beyond slices");
    property p_lr_map;
        !cfg_bus_mode && lr_rd_req_ff |-> lr_rd_addr_ff == sc_addr_ff;
    endproperty
    a_lr_map: assert property (p_lr_map) else $error("link read address differs from scan word");
    property p_bus_lr;
        cfg_bus_mode && lr_rd_req_ff |-> lr_rd_addr_ff[4:0] == sc_addr_ff[4:0];
    endproperty
    a_bus_lr: assert property (p_bus_lr) else $error("bus link read word mismatch");
endmodule : lstm_top_assertions

bind lstm_top lstm_top_assertions u_lstm_top_assertions (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .cfg_bus_mode(cfg_bus_mode), .cfg_ring_asg(cfg_ring_asg), .cfg_bus_attached(cfg_bus_attached),
    .sc_req_ff(sc_req_ff), .sc_we_ff(sc_we_ff), .sc_network_port_index_ff(sc_network_port_index_ff),
    .sc_addr_ff(sc_addr_ff), .sc_ack(sc_ack), .lr_rd_req_ff(lr_rd_req_ff), .lr_rd_addr_ff(lr_rd_addr_ff),
    .lw_valid_ff(lw_valid_ff), .lw_addr_ff(lw_addr_ff));

// *** sim/test_lstm_top.sv ***
`timescale 1ns/1ns
module test_lstm_top
    import lstm_pkg::*;
;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    logic scan_start = 1'h0;
    logic cfg_bus_mode = 1'h0;
    logic [LSTM_ASG_TBL_W-1:0] cfg_ring_asg = '0;
    logic [LSTM_BUS_PORTS-1:0] cfg_bus_attached = '0;
    logic busy_ff, done_ff, sc_req_ff, sc_we_ff, sc_ack, sc_send, lr_rd_req_ff, lw_valid_ff;
    logic lr_rd_ack = 1'h0;
    logic lw_ready = 1'h0;
    logic stall = 1'h0;
    logic [2:0] sc_network_port_index_ff;
    logic [LSTM_ADDR_W-1:0] sc_addr_ff, lr_rd_addr_ff, lw_addr_ff;
    logic [LSTM_DATA_W-1:0] sc_wdata_ff, sc_rdata, lw_data_ff;
    logic [LSTM_DATA_W-1:0] lr_rd_data = '0;
    logic [LSTM_DATA_W-1:0] lr_mem [LSTM_LR_WORDS];
    logic [LSTM_DATA_W-1:0] exp_lr [LSTM_LR_WORDS];
    logic [LSTM_DATA_W-1:0] exp_sc [8192];
    int errors = 0;
    int checked = 0;

    always #20 clk_sys = ~clk_sys;

    // Link register side: reads answered next cycle, released data flips
    always @(negedge clk_sys)
    begin
        lr_rd_ack <= lr_rd_req_ff && !lr_rd_ack;
        lr_rd_data <= lr_rd_req_ff ? lr_mem[lr_rd_addr_ff] : ~lr_rd_data;
        lw_ready <= !stall;
    end
    always @(posedge clk_sys)
    begin
        if (lw_valid_ff && lw_ready)
            lr_mem[lw_addr_ff] <= lw_data_ff;
    end

    lstm_top u_lstm_top (.clk_sys, .sys_rst, .scan_start, .cfg_bus_mode, .cfg_ring_asg, .cfg_bus_attached,
        .busy_ff, .done_ff, .sc_req_ff, .sc_we_ff, .sc_network_port_index_ff, .sc_addr_ff, .sc_wdata_ff,
        .sc_ack, .sc_rdata, .sc_send, .lr_rd_req_ff, .lr_rd_addr_ff, .lr_rd_ack, .lr_rd_data, .lw_valid_ff,
        .lw_addr_ff, .lw_data_ff, .lw_ready);
    lstm_scan_model u_lstm_scan_model (.clk_sys, .sys_rst, .sc_req_ff, .sc_we_ff, .sc_network_port_index_ff,
        .sc_addr_ff, .sc_wdata_ff, .sc_ack, .sc_rdata, .sc_send);

    task fail(input string msg);
        $display("[FAIL] %0t %s", $time, msg);
        errors++;
    endtask : fail

    task report_and_stop;
        if (errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // Expected memories after one scan, from the table and the direction each module reports
    task automatic predict;
        logic [1:0] a, e;
        logic h, da, db;
        logic [15:0] ra, rb, lr;
        int s;
        for (int i = 0; i < 1024; i++)
            exp_lr[i] = lr_mem[i];
        for (int i = 0; i < 8192; i++)
            exp_sc[i] = u_lstm_scan_model.mem[i];
        s = 0;
        for (int p = 0; p < 8 && cfg_bus_mode; p++)
        begin
            if (!cfg_bus_attached[p])
                continue;
            for (int j = 0; j < 32; j++)
                if (j[p + 1])
                    exp_sc[p * 1024 + j] = lr_mem[s * 32 + j];
                else
                    exp_lr[s * 32 + j] = u_lstm_scan_model.mem[p * 1024 + j];
            s++;
        end
        for (int w = 0; w < 1024 && !cfg_bus_mode; w++)
        begin
            a = cfg_ring_asg[2 * (w / 64) +: 2];
            e = (a != 2'h0) ? a : cfg_ring_asg[32 + 2 * (w / 64) +: 2];
            h = (a == 2'h0);
            da = w[1];
            db = w[2];
            ra = u_lstm_scan_model.mem[w];
            rb = u_lstm_scan_model.mem[1024 + w];
            lr = lr_mem[w];
            if (e == 2'h0)
                continue;
            if (e != 2'h2)
            begin
                if (h ? db : da)
                    exp_sc[h * 1024 + w] = lr;
                else
                    exp_lr[w] = h ? rb : ra;
            end
            else if (!da && db)
                {exp_lr[w], exp_sc[1024 + w]} = {ra, ra};
            else if (da && !db)
                {exp_lr[w], exp_sc[w]} = {rb, rb};
            else if (da && db)
                {exp_sc[w], exp_sc[1024 + w]} = {lr, lr};
            else
                exp_lr[w] = h ? rb : ra;
        end
    endtask : predict

    // One full scan; the link side refuses writes for hold cycles, long enough in t_bus_gaps for the buffer to fill
    task automatic run_scan(input int hold);
        int n;
        predict();
        stall = (hold > 0);
        scan_start = 1'h1;
        @(negedge clk_sys);
        scan_start = 1'h0;
        checked++;
        if (busy_ff !== 1'h1)
            fail("busy not raised by start");
        repeat (hold) @(negedge clk_sys);
        stall = 1'h0;
        n = 0;
        while (done_ff !== 1'h1 && n < 20000)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n == 20000)
        begin
            fail("scan never finished");
            report_and_stop();
        end
        @(negedge clk_sys);
        checked++;
        if (done_ff !== 1'h0 || busy_ff !== 1'h0)
            fail("done not a single pulse or still busy");
        for (int i = 0; i < 1024; i++)
        begin
            checked++;
            if (lr_mem[i] !== exp_lr[i])
                fail("link register word wrong");
        end
        for (int i = 0; i < 8192; i++)
        begin
            checked++;
            if (u_lstm_scan_model.mem[i] !== exp_sc[i])
                fail("scan word wrong");
        end
    endtask : run_scan

    // Blank, link, duplicate and bridge blocks on both channels, a code 11 block on the first
    task t_ring_mixed;
        cfg_bus_mode = 1'h0;
        cfg_ring_asg = 64'h4000_2214_8000_1c91;
        run_scan(0);
    endtask : t_ring_mixed

    // Only the second channel set, every block, last word included
    task t_ring_full;
        cfg_ring_asg = 64'hffff_ffff_0000_0000;
        run_scan(0);
    endtask : t_ring_full

    // Gapped attached channels while the link side stalls
    task t_bus_gaps;
        cfg_bus_mode = 1'h1;
        cfg_bus_attached = 8'h5a;
        run_scan(800);
    endtask : t_bus_gaps

    // All eight channels attached
    task t_bus_full;
        cfg_bus_attached = 8'hff;
        run_scan(300);
    endtask : t_bus_full

    initial
    begin
        for (int i = 0; i < 1024; i++)
            lr_mem[i] = 16'(i) ^ 16'ha5a5;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'h0;
        t_ring_mixed();
        t_ring_full();
        t_bus_gaps();
        t_bus_full();
        report_and_stop();
    end
endmodule : test_lstm_top
